// ==== arith_exec_regs.vh ====
// Instruction codes, encoded lengths and cycle counts of the arithmetic unit
`ifndef ARITH_EXEC_REGS_VH
`define ARITH_EXEC_REGS_VH

// Operation code: group in op[4:2], form in op[1:0]
`define GRP_ADD 3'h0
`define GRP_ADD_CARRY 3'h1
`define GRP_SUB_BORROW 3'h2
`define GRP_INC 3'h3
`define GRP_DEC 3'h4
`define GRP_MISC 3'h5
`define GRP_LOAD_AUX 3'h6

// Forms of the operand groups
`define FORM_REG 2'h0
`define FORM_DIR 2'h1
`define FORM_IND 2'h2
`define FORM_IMM 2'h3
`define FORM_ACC 2'h3

// Forms of the miscellaneous group
`define MISC_INC_POINTER 2'h0
`define MISC_MULTIPLY 2'h1
`define MISC_DIV 2'h2
`define MISC_DEC_ADJUST 2'h3

// Encoded lengths in bytes
`define LEN_ONE 2'd1
`define LEN_TWO 2'd2

// Execution cycles
`define CYC_ALU_REG 3'd1
`define CYC_ALU_DIR 3'd2
`define CYC_ALU_IND 3'd2
`define CYC_ALU_IMM 3'd2
`define CYC_INC_ACC 3'd1
`define CYC_INC_REG 3'd2
`define CYC_INC_DIR 3'd3
`define CYC_INC_IND 3'd3
`define CYC_INC_POINTER 3'd1
`define CYC_MULTIPLY 3'd2
`define CYC_DIV 3'd6
`define CYC_DEC_ADJUST 3'd3
`define CYC_LOAD_AUX 3'd1

// Divider iterations, two quotient bits each
`define DIV_STEPS 3'd4

// Reset values
`define ACC_RESET 8'h00
`define AUX_RESET 8'h00
`define POINTER_RESET 16'h0000

`endif

// ==== div_radix4.v ====
// Sequential 8-bit divider producing two quotient bits per cycle
`include "arith_exec_regs.vh"

module div_radix4 (
  input wire clk,
  input wire nrst,
  input wire start,
  input wire [7:0] dividend,
  input wire [7:0] divisor,
  output reg [7:0] quot,
  output reg [7:0] rem
);

  reg [7:0] dsr;
  reg [2:0] steps;
  reg [7:0] t_q;
  reg [7:0] t_r;
  reg [9:0] trial;
  integer i;

  // Two restoring steps per clock
  always @* begin
    t_q = quot;
    t_r = rem;
    trial = 10'h000;
    for (i = 0; i < 2; i = i + 1) begin
      trial = {1'b0, t_r, t_q[7]} - {2'b00, dsr};
      if (!trial[9]) begin
        t_r = trial[7:0];
        t_q = {t_q[6:0], 1'b1};
      end else begin
        t_r = {t_r[6:0], t_q[7]};
        t_q = {t_q[6:0], 1'b0};
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      quot <= 8'h00;
      rem <= 8'h00;
      dsr <= 8'h00;
      steps <= 3'h0;
    end else if (start) begin
      quot <= dividend;
      rem <= 8'h00;
      dsr <= divisor;
      steps <= `DIV_STEPS;
    end else if (steps != 3'h0) begin
      quot <= t_q;
      rem <= t_r;
      steps <= steps - 3'h1;
    end
  end

endmodule

// ==== arith_exec_unit.v ====
// Arithmetic execution unit: add, carry add, borrow subtract, inc/dec, multiply, divide, decimal adjust
`include "arith_exec_regs.vh"

module arith_exec_unit (
  input wire clk,
  input wire nrst,
  input wire start,
  input wire [4:0] op,
  input wire [7:0] src_byte,
  input wire [7:0] ptr_val,
  input wire [7:0] mem_rdata,
  output wire ready,
  output wire done,
  output reg [1:0] instr_len,
  output wire mem_rd,
  output wire mem_wr,
  output reg [7:0] mem_addr,
  output reg [7:0] mem_wdata,
  output wire reg_wr,
  output reg [7:0] reg_wdata,
  output reg [7:0] acc,
  output reg [7:0] aux,
  output reg [15:0] data_pointer_16,
  output reg carry,
  output reg aux_carry,
  output reg overflow
);

  localparam S_IDLE = 2'b01;
  localparam S_RUN = 2'b10;

  reg [1:0] state;
  reg [4:0] op_q;
  reg [7:0] src_q;
  reg [7:0] opnd_q;
  reg [2:0] cnt;
  reg first;

  wire [2:0] grp = op[4:2];
  wire [1:0] form = op[1:0];
  wire [2:0] grp_q = op_q[4:2];
  wire [1:0] form_q = op_q[1:0];
  wire is_idle = state[0];
  wire is_run = state[1];
  wire take = is_idle & start;

  // Cycle count and byte length of the offered instruction
  reg [2:0] cyc;
  reg [1:0] len;
  always @* begin
    cyc = `CYC_ALU_REG;
    len = `LEN_ONE;
    case (grp)
      `GRP_ADD, `GRP_ADD_CARRY, `GRP_SUB_BORROW: begin
        case (form)
          `FORM_REG: cyc = `CYC_ALU_REG;
          `FORM_DIR: begin
            cyc = `CYC_ALU_DIR;
            len = `LEN_TWO;
          end
          `FORM_IND: cyc = `CYC_ALU_IND;
          default: begin
            cyc = `CYC_ALU_IMM;
            len = `LEN_TWO;
          end
        endcase
      end
      `GRP_INC, `GRP_DEC: begin
        case (form)
          `FORM_REG: cyc = `CYC_INC_REG;
          `FORM_DIR: begin
            cyc = `CYC_INC_DIR;
            len = `LEN_TWO;
          end
          `FORM_IND: cyc = `CYC_INC_IND;
          default: cyc = `CYC_INC_ACC;
        endcase
      end
      `GRP_LOAD_AUX: cyc = `CYC_LOAD_AUX;
      default: begin
        case (form)
          `MISC_INC_POINTER: cyc = `CYC_INC_POINTER;
          `MISC_MULTIPLY: cyc = `CYC_MULTIPLY;
          `MISC_DIV: cyc = `CYC_DIV;
          default: cyc = `CYC_DEC_ADJUST;
        endcase
      end
    endcase
  end

  wire op_grp_q = (grp_q != `GRP_MISC);
  wire mem_form_q = op_grp_q & ((form_q == `FORM_DIR) | (form_q == `FORM_IND));
  wire incdec_q = (grp_q == `GRP_INC) | (grp_q == `GRP_DEC);
  wire last = is_run & (cnt == 3'h1);

  assign ready = is_idle;
  assign done = (take & (cyc == 3'h1)) | last;
  assign mem_rd = is_run & first & mem_form_q;
  assign mem_wr = last & incdec_q & mem_form_q;
  assign reg_wr = last & incdec_q & (form_q == `FORM_REG);

  // Operation and operand seen by the datapath this cycle
  wire [4:0] x_op = is_idle ? op : op_q;
  wire [2:0] x_grp = x_op[4:2];
  wire [1:0] x_form = x_op[1:0];
  wire [7:0] x_opnd = is_idle ? src_byte :
                      (mem_form_q ? (first ? mem_rdata : opnd_q) : src_q);

  // Adder and subtractor with nibble carry
  wire cin = (x_grp == `GRP_ADD) ? 1'b0 : carry;
  wire [8:0] sum = {1'b0, acc} + {1'b0, x_opnd} + {8'h00, cin};
  wire [4:0] sum_lo = {1'b0, acc[3:0]} + {1'b0, x_opnd[3:0]} + {4'h0, cin};
  wire [8:0] diff = {1'b0, acc} - {1'b0, x_opnd} - {8'h00, carry};
  wire [4:0] diff_lo = {1'b0, acc[3:0]} - {1'b0, x_opnd[3:0]} - {4'h0, carry};
  wire [15:0] prod = acc * aux;
  wire [7:0] quot;
  wire [7:0] rem;

  // Decimal adjust
  wire low_fix = (acc[3:0] > 4'h9) | aux_carry;
  wire [8:0] da1 = {1'b0, acc} + (low_fix ? 9'h006 : 9'h000);
  wire hi_fix = (da1[7:4] > 4'h9) | carry | da1[8];
  wire [8:0] da2 = {1'b0, da1[7:0]} + (hi_fix ? 9'h060 : 9'h000);

  div_radix4 i_div_radix4 (
    .clk(clk),
    .nrst(nrst),
    .start(take & (op == {`GRP_MISC, `MISC_DIV})),
    .dividend(acc),
    .divisor(aux),
    .quot(quot),
    .rem(rem)
  );

  wire fire = done;

  always @(posedge clk) begin
    if (!nrst) begin
      state <= S_IDLE;
      op_q <= 5'h00;
      src_q <= 8'h00;
      opnd_q <= 8'h00;
      cnt <= 3'h0;
      first <= 1'b0;
      instr_len <= 2'h0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
      reg_wdata <= 8'h00;
    end else begin
      first <= take;
      case (state)
        S_IDLE: begin
          if (start) begin
            op_q <= op;
            src_q <= src_byte;
            instr_len <= len;
            cnt <= cyc - 3'h1;
            // Direct forms address by the operand byte, indirect by the pointer
            mem_addr <= (form == `FORM_IND) ? ptr_val : src_byte;
            if (grp == `GRP_INC)
              reg_wdata <= src_byte + 8'h01;
            else
              reg_wdata <= src_byte - 8'h01;
            if (cyc != 3'h1)
              state <= S_RUN;
          end
        end
        S_RUN: begin
          cnt <= cnt - 3'h1;
          if (first) begin
            opnd_q <= mem_rdata;
            if (grp_q == `GRP_INC)
              mem_wdata <= mem_rdata + 8'h01;
            else
              mem_wdata <= mem_rdata - 8'h01;
          end
          if (last)
            state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Architectural state updates on the completing cycle
  always @(posedge clk) begin
    if (!nrst) begin
      acc <= `ACC_RESET;
      aux <= `AUX_RESET;
      data_pointer_16 <= `POINTER_RESET;
      carry <= 1'b0;
      aux_carry <= 1'b0;
      overflow <= 1'b0;
    end else if (fire) begin
      case (x_grp)
        `GRP_ADD, `GRP_ADD_CARRY: begin
          acc <= sum[7:0];
          carry <= sum[8];
          aux_carry <= sum_lo[4];
          overflow <= (acc[7] == x_opnd[7]) & (sum[7] != acc[7]);
        end
        `GRP_SUB_BORROW: begin
          acc <= diff[7:0];
          carry <= diff[8];
          aux_carry <= diff_lo[4];
          overflow <= (acc[7] != x_opnd[7]) & (diff[7] != acc[7]);
        end
        `GRP_INC: begin
          if (x_form == `FORM_ACC)
            acc <= acc + 8'h01;
        end
        `GRP_DEC: begin
          if (x_form == `FORM_ACC)
            acc <= acc - 8'h01;
        end
        // Auxiliary operand written from src_byte, no flags touched
        `GRP_LOAD_AUX: aux <= x_opnd;
        default: begin
          case (x_form)
            `MISC_INC_POINTER: data_pointer_16 <= data_pointer_16 + 16'h0001;
            `MISC_MULTIPLY: begin
              acc <= prod[7:0];
              aux <= prod[15:8];
              carry <= 1'b0;
              overflow <= (prod[15:8] != 8'h00);
            end
            `MISC_DIV: begin
              // Zero divisor leaves the operands and flags overflow
              if (aux != 8'h00) begin
                acc <= quot;
                aux <= rem;
              end
              carry <= 1'b0;
              overflow <= (aux == 8'h00);
            end
            default: begin
              acc <= da2[7:0];
              carry <= carry | da1[8] | da2[8];
            end
          endcase
        end
      endcase
    end
  end

endmodule

// ==== arith_checker.sv ====
// Cycle and strobe checks for the arithmetic execution unit
module arith_checker (
  input wire clk,
  input wire nrst,
  input wire start,
  input wire [4:0] op,
  input wire [7:0] ptr_val,
  input wire ready,
  input wire done,
  input wire [1:0] instr_len,
  input wire mem_rd,
  input wire mem_wr,
  input wire [7:0] mem_addr,
  input wire reg_wr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire take = start & ready;
  reg_add_a: assert property (take && op == 5'h00 |-> done)
    else $error("reg add late");
  dir_add_a: assert property (take && op == 5'h01 |=> mem_rd && done && instr_len == 2'h2)
    else $error("direct add timing");
  ind_add_a: assert property (take && op == 5'h02 |=> mem_rd && done && mem_addr == $past(ptr_val))
    else $error("indirect add timing");
  imm_add_a: assert property (take && op == 5'h03 |=> done && !mem_rd)
    else $error("immediate add timing");
  reg_carry_a: assert property (take && (op == 5'h04 || op == 5'h08) |-> done ##1 ready)
    else $error("carry reg op timing");
  inc_mem_a: assert property (take && op == 5'h0d |=> mem_rd && !done ##1 mem_wr && done)
    else $error("inc direct timing");
  inc_reg_a: assert property (take && op == 5'h0c |=> reg_wr && done)
    else $error("inc reg timing");
  mul_time_a: assert property (take && op == 5'h15 |=> done)
    else $error("multiply timing");
  div_time_a: assert property (take && op == 5'h16 |-> !done ##1 (!done && !ready)[*4] ##1 done)
    else $error("divide timing");
  dec_adj_a: assert property (take && op == 5'h17 |=> !done ##1 done)
    else $error("decimal adjust timing");
endmodule

bind arith_exec_unit arith_checker i_arith_checker (.clk(clk), .nrst(nrst), .start(start),
  .op(op), .ptr_val(ptr_val), .ready(ready), .done(done), .instr_len(instr_len),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .reg_wr(reg_wr));

// ==== tb_arith_instr_exec_timing.sv ====
// Self-checking bench for the arithmetic execution unit
module tb_arith_instr_exec_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, start;
  logic [4:0] op;
  logic [7:0] src_byte, ptr_val;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] wseen = 8'h00;
  wire ready, done, mem_rd, mem_wr, reg_wr, carry, aux_carry, overflow;
  wire [1:0] instr_len;
  wire [7:0] mem_addr, mem_wdata, reg_wdata, acc, aux;
  wire [15:0] data_pointer_16;
  integer failures = 0;
  integer checked = 0;
  arith_exec_unit i_arith_exec_unit (.clk(clk), .nrst(nrst), .start(start), .op(op),
    .src_byte(src_byte), .ptr_val(ptr_val), .mem_rdata(mem_rdata), .ready(ready),
    .done(done), .instr_len(instr_len), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .acc(acc), .aux(aux), .data_pointer_16(data_pointer_16), .carry(carry),
    .aux_carry(aux_carry), .overflow(overflow));
  always #10 clk = ~clk;
  // Read-only memory model, writes not stored: 0x20 holds 0x35, anything else 0xc0
  always @(negedge clk) mem_rdata <= (mem_addr == 8'h20) ? 8'h35 : 8'hc0;
  always @(posedge clk) if (mem_wr) wseen <= mem_wdata; else if (reg_wr) wseen <= reg_wdata;
  task results;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Overflow, carry and accumulator in one word
  task ac(input logic [15:0] e);
    chk("ovf_carry_acc", {6'h00, overflow, carry, acc}, e);
  endtask
  task run(input logic [4:0] o, input logic [7:0] s, input logic [2:0] n, input logic [1:0] l);
    integer k;
    begin
      @(negedge clk);
      op = o;
      src_byte = s;
      start = 1'b1;
      k = 1;
      #1;
      while (done !== 1'b1 && k < 9) begin
        @(negedge clk);
        start = 1'b0;
        #1;
        k = k + 1;
      end
      @(posedge clk);
      #1;
      chk("cycles", k[15:0], {13'h0000, n});
      chk("length", {14'h0000, instr_len}, {14'h0000, l});
    end
  endtask
  task t_reset;
    begin
      ac(16'h0000);
      chk("aux", {8'h00, aux}, 16'h0000);
      chk("data_pointer_16", data_pointer_16, 16'h0000);
      chk("ready", {15'h0000, ready}, 16'h0001);
      $display("test reset done");
    end
  endtask
  task t_add;
    begin
      run(5'h03, 8'h10, 3'h2, 2'h2); ac(16'h0010);
      run(5'h00, 8'h05, 3'h1, 2'h1); ac(16'h0015);
      run(5'h01, 8'h20, 3'h2, 2'h2); ac(16'h004a);
      run(5'h02, 8'h00, 3'h2, 2'h1); ac(16'h010a);
      $display("test add done");
    end
  endtask
  task t_add_with_carry;
    begin
      run(5'h04, 8'h01, 3'h1, 2'h1); ac(16'h000c);
      run(5'h07, 8'hff, 3'h2, 2'h2); ac(16'h010b);
      chk("aux_carry", {15'h0000, aux_carry}, 16'h0001);
      run(5'h05, 8'h20, 3'h2, 2'h2); ac(16'h0041);
      run(5'h06, 8'h00, 3'h2, 2'h1); ac(16'h0101);
      $display("test add with carry done");
    end
  endtask
  task t_subtract_with_borrow;
    begin
      run(5'h08, 8'h00, 3'h1, 2'h1); ac(16'h0000);
      run(5'h0b, 8'h01, 3'h2, 2'h2); ac(16'h01ff);
      run(5'h09, 8'h20, 3'h2, 2'h2); ac(16'h00c9);
      run(5'h0a, 8'h00, 3'h2, 2'h1); ac(16'h0009);
      chk("aux_carry", {15'h0000, aux_carry}, 16'h0000);
      $display("test subtract with borrow done");
    end
  endtask
  task t_incdec;
    begin
      run(5'h0f, 8'h00, 3'h1, 2'h1); ac(16'h000a);
      run(5'h13, 8'h00, 3'h1, 2'h1); ac(16'h0009);
      run(5'h0c, 8'h7f, 3'h2, 2'h1); chk("wb", {8'h00, wseen}, 16'h0080);
      run(5'h10, 8'h00, 3'h2, 2'h1); chk("wb", {8'h00, wseen}, 16'h00ff);
      run(5'h11, 8'h20, 3'h3, 2'h2); chk("wb", {8'h00, wseen}, 16'h0034);
      run(5'h0e, 8'h00, 3'h3, 2'h1); chk("wb", {8'h00, wseen}, 16'h00c1);
      $display("test inc dec done");
    end
  endtask
  task t_misc;
    begin
      run(5'h16, 8'h00, 3'h6, 2'h1); ac(16'h0209);
      run(5'h15, 8'h00, 3'h2, 2'h1); ac(16'h0000);
      chk("aux", {8'h00, aux}, 16'h0000);
      run(5'h03, 8'h9b, 3'h2, 2'h2); ac(16'h009b);
      run(5'h17, 8'h00, 3'h3, 2'h1); ac(16'h0101);
      run(5'h14, 8'h00, 3'h1, 2'h1); chk("data_pointer_16", data_pointer_16, 16'h0001);
      // Divide and multiply with a loaded auxiliary operand
      run(5'h18, 8'h0d, 3'h1, 2'h1); chk("aux", {8'h00, aux}, 16'h000d);
      run(5'h03, 8'hc7, 3'h2, 2'h2); ac(16'h00c8);
      run(5'h16, 8'h00, 3'h6, 2'h1); ac(16'h000f);
      chk("aux", {8'h00, aux}, 16'h0005);
      run(5'h18, 8'h20, 3'h1, 2'h1); chk("aux", {8'h00, aux}, 16'h0020);
      run(5'h15, 8'h00, 3'h2, 2'h1); ac(16'h02e0);
      chk("aux", {8'h00, aux}, 16'h0001);
      $display("test misc done");
    end
  endtask
  initial begin
    #20000;
    failures = failures + 1;
    results;
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    start = 1'b0;
    op = 5'h00;
    src_byte = 8'h00;
    ptr_val = 8'h21;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_reset;
    t_add;
    t_add_with_carry;
    t_subtract_with_borrow;
    t_incdec;
    t_misc;
    results;
  end
endmodule
